// *** rtl/dcg_pkg.sv ***
package dcg_pkg;
	// Bus map of the deep-sleep gating register
	localparam logic [31:0] SCB_BASE        = 32'h400F_E000;
	localparam logic [11:0] DSCG1_OFFSET    = 12'h0124;
	localparam logic [31:0] DSCG1_RESET     = 32'h0000_0000;
	localparam logic [31:0] DSCG1_WMASK     = 32'h0303_0011;
	// Enable bit positions
	localparam int BIT_ASYNC_SERIAL = 0;
	localparam int BIT_SYNC_SERIAL  = 4;
	localparam int BIT_TIMER_A      = 16;
	localparam int BIT_TIMER_B      = 17;
	localparam int BIT_COMP_A       = 24;
	localparam int BIT_COMP_B       = 25;
	localparam int NUM_UNITS        = 6;
	// Address window of each gated unit, index order as the bit list above
	localparam logic [31:0] UNIT_BASE [NUM_UNITS] = '{
		32'h4000_C000, 32'h4000_8000, 32'h4003_0000,
		32'h4003_1000, 32'h4003_C000, 32'h4003_C000};
	localparam logic [31:0] UNIT_SIZE = 32'h0000_1000;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;
endpackage : dcg_pkg

// *** rtl/dcg_gate.sv ***
`timescale 1ns/1ps
module dcg_gate (
	input  wire logic        MCLK,
	input  wire logic        RSTN,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        DEEP_SLEEP,
	input  wire logic        AUTO_CLOCK_GATING_SELECT,
	input  wire logic [31:0] NORMAL_GATE,
	input  wire logic        UNIT_SEL,
	input  wire logic [31:0] UNIT_ADDR,
	input  wire logic [1:0]  UNIT_TRANS,
	output logic             UNIT_FAULT,
	output logic [5:0]       UNIT_CLOCK_ENABLE
);
	logic [31:0] deep_sleep_clock_gate_1;
	logic        wr_pend;
	logic        ds_q1;
	logic        ds_q2;
	logic        acg_q1;
	logic        acg_q2;
	logic [31:0] gate_sel;
	logic [5:0]  next_enable;
	logic        reg_hit;
	logic        unit_hit;
	logic        err_first;
	logic        err_second;
	logic        fault_q;

	// Mode pins come from the power controller, so synchronise first
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ds_q1  <= 1'b0;
			ds_q2  <= 1'b0;
			acg_q1 <= 1'b0;
			acg_q2 <= 1'b0;
		end else begin
			ds_q1  <= DEEP_SLEEP;
			ds_q2  <= ds_q1;
			acg_q1 <= AUTO_CLOCK_GATING_SELECT;
			acg_q2 <= acg_q1;
		end
	end

	// Address phase decode of our own register
	assign reg_hit = HSEL && HREADY && HTRANS[1]
		&& (HADDR == (dcg_pkg::SCB_BASE
		+ {20'h0_0000, dcg_pkg::DSCG1_OFFSET}));

	// Write data arrives one cycle after the address phase
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= reg_hit && HWRITE;
		end
	end

	// Only the six enable bits store; reserved bits stay zero
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			deep_sleep_clock_gate_1 <= dcg_pkg::DSCG1_RESET;
		end else if (wr_pend) begin
			deep_sleep_clock_gate_1 <= HWDATA & dcg_pkg::DSCG1_WMASK;
		end
	end

	// Read data registered at the address phase; no wait states
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			HRDATA <= 32'h0000_0000;
		end else if (reg_hit && !HWRITE) begin
			HRDATA <= deep_sleep_clock_gate_1;
		end else begin
			HRDATA <= 32'h0000_0000;
		end
	end
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	// Deep-sleep set applies only with auto gating; else normal set
	assign gate_sel = (ds_q2 && acg_q2) ? deep_sleep_clock_gate_1
		: NORMAL_GATE;

	always_comb begin
		next_enable[0] = gate_sel[dcg_pkg::BIT_ASYNC_SERIAL];
		next_enable[1] = gate_sel[dcg_pkg::BIT_SYNC_SERIAL];
		next_enable[2] = gate_sel[dcg_pkg::BIT_TIMER_A];
		next_enable[3] = gate_sel[dcg_pkg::BIT_TIMER_B];
		next_enable[4] = gate_sel[dcg_pkg::BIT_COMP_A];
		next_enable[5] = gate_sel[dcg_pkg::BIT_COMP_B];
	end

	// Registered enables feed the clock-gate cells glitch free
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			UNIT_CLOCK_ENABLE <= 6'h00;
		end else begin
			UNIT_CLOCK_ENABLE <= next_enable;
		end
	end

	// An access to any gated-off unit window is a fault
	always_comb begin
		unit_hit = 1'b0;
		for (int i = 0; i < dcg_pkg::NUM_UNITS; i++) begin
			if (!UNIT_CLOCK_ENABLE[i]
				&& (UNIT_ADDR >= dcg_pkg::UNIT_BASE[i])
				&& (UNIT_ADDR - dcg_pkg::UNIT_BASE[i] < dcg_pkg::UNIT_SIZE)) begin
				unit_hit = 1'b1;
			end
		end
	end

	// Two-cycle AHB error response toward the unit's bus segment
	assign err_first = UNIT_SEL && UNIT_TRANS[1] && unit_hit;
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			fault_q    <= 1'b0;
			err_second <= 1'b0;
		end else begin
			fault_q    <= err_first && !fault_q && !err_second;
			err_second <= fault_q;
		end
	end
	assign UNIT_FAULT = fault_q || err_second;

	// Register word: reserved positions never hold a one
	chk_reserved_zero: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		(deep_sleep_clock_gate_1 & ~dcg_pkg::DSCG1_WMASK) == 32'h0000_0000)
		else $error("reserved bit set");

	// A write lands at the edge after its data phase starts
	chk_write_store: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		reg_hit && HWRITE |=> ##1
		deep_sleep_clock_gate_1 == ($past(HWDATA) & dcg_pkg::DSCG1_WMASK))
		else $error("write not stored");

	// Write data is only trusted in the data phase that follows
	// Only a decoded write may change the word; stray traffic must not
	chk_write_only: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		!$past(wr_pend) |-> $stable(deep_sleep_clock_gate_1))
		else $error("register changed without a write");

	// Address decode: reads never store, foreign addresses are ignored
	chk_read_no_store: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		reg_hit && !HWRITE |=> !wr_pend)
		else $error("read started a write");
	chk_write_pend: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		reg_hit && HWRITE |=> wr_pend)
		else $error("decoded write not taken");
	chk_miss_ignored: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		!reg_hit |=> !wr_pend)
		else $error("write taken at a foreign address");

	// Read data stands for the data phase only, zero otherwise
	chk_read_value: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		reg_hit && !HWRITE |=> HRDATA == $past(deep_sleep_clock_gate_1))
		else $error("read data wrong");
	chk_read_idle: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		!(reg_hit && !HWRITE) |=> HRDATA == 32'h0000_0000)
		else $error("read data outside data phase");

	// Reset clears word and enables; no disable here on purpose
	// A reset value that left a unit clocked would waste deep-sleep power
	chk_reset_word: assert property (
		@(posedge MCLK)
		!RSTN |=> deep_sleep_clock_gate_1 == dcg_pkg::DSCG1_RESET)
		else $error("register not cleared by reset");
	chk_reset_enable: assert property (
		@(posedge MCLK)
		!RSTN |=> UNIT_CLOCK_ENABLE == 6'h00)
		else $error("enables not cleared by reset");
	chk_reset_read: assert property (
		@(posedge MCLK)
		!RSTN |=> HRDATA == 32'h0000_0000)
		else $error("read data not cleared by reset");
	chk_reset_fault: assert property (
		@(posedge MCLK)
		!RSTN |=> !UNIT_FAULT)
		else $error("fault not cleared by reset");

	// Mode pins pass both flops; a skipped stage risks metastability
	chk_mode_first: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		1'b1 |=> ds_q1 == $past(DEEP_SLEEP)
		&& acg_q1 == $past(AUTO_CLOCK_GATING_SELECT))
		else $error("mode pin not captured");
	chk_mode_sync: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		1'b1 |=> ds_q2 == $past(ds_q1) && acg_q2 == $past(acg_q1))
		else $error("mode synchroniser skipped a stage");

	// Enables follow the selected word one edge later
	chk_deep_apply: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		ds_q2 && acg_q2 |=> UNIT_CLOCK_ENABLE[5]
		== $past(deep_sleep_clock_gate_1[dcg_pkg::BIT_COMP_B]))
		else $error("deep enable not applied");
	chk_normal_apply: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		!ds_q2 |=> UNIT_CLOCK_ENABLE[0]
		== $past(NORMAL_GATE[dcg_pkg::BIT_ASYNC_SERIAL]))
		else $error("normal enable not applied");
	chk_gate_off: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		ds_q2 && acg_q2 && !deep_sleep_clock_gate_1[dcg_pkg::BIT_TIMER_A]
		|=> !UNIT_CLOCK_ENABLE[2])
		else $error("timer a clock not stopped");

	// Unit index to register bit, written out apart from the decode
	localparam int UNIT_BIT [dcg_pkg::NUM_UNITS] = '{
		dcg_pkg::BIT_ASYNC_SERIAL, dcg_pkg::BIT_SYNC_SERIAL,
		dcg_pkg::BIT_TIMER_A,      dcg_pkg::BIT_TIMER_B,
		dcg_pkg::BIT_COMP_A,       dcg_pkg::BIT_COMP_B};

	// Every unit: enable tracks its bit, and a gated unit faults
	// The comparator windows share one base, so either gated faults both
	for (genvar g = 0; g < dcg_pkg::NUM_UNITS; g++) begin : g_unit_chk
		chk_deep_bit: assert property (
			@(posedge MCLK) disable iff (!RSTN)
			ds_q2 && acg_q2 |=> UNIT_CLOCK_ENABLE[g]
			== $past(deep_sleep_clock_gate_1[UNIT_BIT[g]]))
			else $error("deep enable bit not applied");
		chk_normal_bit: assert property (
			@(posedge MCLK) disable iff (!RSTN)
			!(ds_q2 && acg_q2) |=> UNIT_CLOCK_ENABLE[g]
			== $past(NORMAL_GATE[UNIT_BIT[g]]))
			else $error("normal enable bit not applied");
		chk_unit_fault: assert property (
			@(posedge MCLK) disable iff (!RSTN)
			UNIT_SEL && UNIT_TRANS[1] && !UNIT_CLOCK_ENABLE[g]
			&& UNIT_ADDR == dcg_pkg::UNIT_BASE[g]
			&& !fault_q && !err_second |=> fault_q)
			else $error("gated unit access not faulted");
	end

	// Fault response: two cycles, only with a cause, never back to back
	// Further hits during the response are dropped; the master retries
	chk_fault_pair: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		$rose(fault_q) |=> err_second ##1 !err_second)
		else $error("fault response not two cycles");
	chk_fault_cause: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		$rose(fault_q) |-> $past(err_first))
		else $error("fault without cause");
	chk_fault_held: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		fault_q |=> UNIT_FAULT)
		else $error("fault dropped after one cycle");
	chk_fault_gap: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		err_second |=> !fault_q)
		else $error("fault restarted without a gap");
	chk_fault_none: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		!err_first |=> !fault_q)
		else $error("fault with no gated access");

	// The register bus itself never stalls or errors
	// Unmapped offsets also answer OKAY; only gated units raise faults
	chk_okay_resp: assert property (
		@(posedge MCLK) disable iff (!RSTN)
		HREADYOUT && !HRESP)
		else $error("register bus not okay");

	// Main scenarios
	cov_write: cover property (@(posedge MCLK) reg_hit && HWRITE);
	cov_read: cover property (@(posedge MCLK) reg_hit && !HWRITE);
	cov_fault: cover property (@(posedge MCLK) $rose(fault_q));
	cov_deep: cover property (@(posedge MCLK) ds_q2 && acg_q2);
	cov_normal: cover property (@(posedge MCLK) RSTN && !ds_q2);
endmodule : dcg_gate

// *** testbench/test_deep_sleep_clock_gate_reg1.sv ***
`timescale 1ns/1ps
module test_deep_sleep_clock_gate_reg1;
	localparam logic [31:0] REG_ADDR = 32'h400F_E124;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        deep = 1'b0;
	logic        auto_sel = 1'b0;
	logic        usel = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [1:0]  utrans = 2'b00;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] normal = 32'h0000_0000;
	logic [31:0] uaddr = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic        hready;
	logic        fault;
	logic        hresp;
	logic [5:0]  ucen;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;

	always #2.5 mclk = ~mclk;

	// Single slave, so its ready output is the bus ready
	dcg_gate i_dut (.MCLK(mclk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.DEEP_SLEEP(deep), .AUTO_CLOCK_GATING_SELECT(auto_sel),
		.NORMAL_GATE(normal), .UNIT_SEL(usel), .UNIT_ADDR(uaddr),
		.UNIT_TRANS(utrans), .UNIT_FAULT(fault), .UNIT_CLOCK_ENABLE(ucen));

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	// One single transfer; each phase held until ready is sampled high
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= dcg_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus

	// One-cycle peripheral access; the fault shows in the next cycle
	task automatic unit(input int i, input logic exp);
		usel <= 1'b1;
		utrans <= dcg_pkg::HTRANS_NONSEQ;
		uaddr <= dcg_pkg::UNIT_BASE[i] + 32'h0000_0004;
		@(posedge mclk);
		usel <= 1'b0;
		utrans <= 2'b00;
		@(posedge mclk);
		chk({31'h0, fault}, {31'h0, exp});
		repeat (3) @(posedge mclk);
	endtask : unit

	task automatic close_out();
		$display("checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	// Ceiling far above the roughly 55 cycles the tests take
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			close_out();
		end
	end

	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		bus(1'b0, REG_ADDR, 32'h0);
		chk(q, 32'h0000_0000);
		chk({26'h0, ucen}, 32'h0000_0000);
		$display("test reset done");
		bus(1'b1, REG_ADDR, 32'hFFFF_FFFF);
		bus(1'b1, 32'h400F_E120, 32'h0000_0000);
		bus(1'b0, 32'h400F_E128, 32'h0);
		chk(q, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0000_0000);
		bus(1'b0, REG_ADDR, 32'h0);
		chk(q, 32'h0303_0011);
		// Mode pins pass a two-flop sync, so allow a few edges
		deep <= 1'b1;
		auto_sel <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({26'h0, ucen}, 32'h0000_003F);
		bus(1'b1, REG_ADDR, 32'h0100_0010);
		repeat (2) @(posedge mclk);
		chk({26'h0, ucen}, 32'h0000_0012);
		for (int i = 0; i < 4; i++)
			unit(i, i != 1);
		$display("test enables and faults done");
		bus(1'b1, REG_ADDR, 32'hFCFC_FFEE);
		bus(1'b0, REG_ADDR, 32'h0);
		chk(q, 32'h0000_0000);
		auto_sel <= 1'b0;
		normal <= 32'h0000_0001;
		repeat (4) @(posedge mclk);
		chk({26'h0, ucen}, 32'h0000_0001);
		auto_sel <= 1'b1;
		deep <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({26'h0, ucen}, 32'h0000_0001);
		$display("test reserved and modes done");
		close_out();
	end
endmodule : test_deep_sleep_clock_gate_reg1
